/* File: logic/adc_serial_port_and_channel_scan.sv */
// Functional notes
// - Serial clock idle past 4096 (or 256) clocks resets the serial port.
// - Serial output released within 5 clocks after chip select goes high.
// - New result while unread: ready output high one clock, then low.
// - New data stands on serial output before ready falls.
// - One mode bit picks automatic scan or fixed channel.
// - Automatic scan steps enabled channels, break before make.
// - Selector routes at most one source (none while open): single, differential or monitor.
// - Conversion starts paced at no more than 23.7 kSPS in total, across all channels.
// - Clock from crystal or external input; clock out only on crystal.
// - Input sampled on rising serial clock, output changed on falling.
// - Ready output is active low.
// - Chip select active low; port responds only while it is low.
// - Start input active high requests conversions.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_port_and_channel_scan #(
  parameter int unsigned SCAN_MIN_CYC = adc_scan_pkg::SCAN_MIN_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  output logic dout_o,
  output logic dout_oe,
  output logic conversion_ready_n,
  // Conversion control
  input wire logic start_pin,
  input wire logic conv_done,
  input wire logic [adc_scan_pkg::RESULT_BITS-1:0] conv_result,
  output logic conv_start,
  // Received command bytes
  output logic cmd_valid,
  output logic [adc_scan_pkg::CMD_BITS-1:0] cmd_byte,
  // Setup levels
  input wire logic channel_access_mode_bit,
  input wire logic [adc_scan_pkg::NUM_SOURCES-1:0] channel_enable,
  input wire logic [4:0] fixed_channel_addr,
  input wire logic short_timeout,
  // Selector
  output adc_scan_pkg::selector_t selector,
  output logic [adc_scan_pkg::NUM_SOURCES-1:0] switch_closed,
  // Clock source
  input wire logic clock_src_ext_pin,
  input wire logic clock_out_enable,
  output logic clock_pin_bidir_o,
  output logic clock_pin_bidir_oe
);

  // ==========================================================
  // Pin synchronisers
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic sclk_last_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta_reg <= 6'h02;
      pin_sync_reg <= 6'h02;
      sclk_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {clock_out_enable, clock_src_ext_pin, start_pin, din_pin, cs_n_pin,
                       sclk_pin};
      pin_sync_reg <= pin_meta_reg;
      sclk_last_reg <= pin_sync_reg[0];
    end
  end
  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_low = !pin_sync_reg[1];
  assign sclk_rise = pin_sync_reg[0] && !sclk_last_reg;
  assign sclk_fall = !pin_sync_reg[0] && sclk_last_reg;

  // ==========================================================
  // Idle serial clock watchdog
  logic [12:0] idle_reg;
  logic timeout;
  logic [12:0] idle_limit;
  assign idle_limit = short_timeout ? 13'(adc_scan_pkg::TIMEOUT_SHORT_CYC - 1) :
                                      13'(adc_scan_pkg::TIMEOUT_LONG_CYC - 1);
  assign timeout = (idle_reg == idle_limit) && !sclk_rise && !sclk_fall;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || sclk_rise || sclk_fall || timeout) begin
      idle_reg <= adc_scan_pkg::IDLE_RESET;
    end else begin
      idle_reg <= idle_reg + 13'h0001;
    end
  end

  // ==========================================================
  // Command receive
  logic [2:0] bit_reg;
  logic [adc_scan_pkg::CMD_BITS-1:0] rx_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || timeout || !cs_low) begin
      bit_reg <= adc_scan_pkg::BIT_RESET;
      rx_reg <= '0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (sclk_rise) begin
        rx_reg <= {rx_reg[6:0], pin_sync_reg[2]};
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h7) begin
          cmd_valid <= 1'b1;
          cmd_byte <= {rx_reg[6:0], pin_sync_reg[2]};
        end
      end
    end
  end

  // ==========================================================
  // Result shift out and ready strobe
  logic [adc_scan_pkg::RESULT_BITS-1:0] tx_reg;
  logic fall_pend_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_reg <= '0;
      dout_o <= 1'b0;
    end else if (conv_done) begin
      dout_o <= conv_result[adc_scan_pkg::RESULT_BITS-1];
      tx_reg <= {conv_result[adc_scan_pkg::RESULT_BITS-2:0], 1'b0};
    end else if (sclk_fall && cs_low) begin
      dout_o <= tx_reg[adc_scan_pkg::RESULT_BITS-1];
      tx_reg <= {tx_reg[adc_scan_pkg::RESULT_BITS-2:0], 1'b0};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      conversion_ready_n <= 1'b1;
      fall_pend_reg <= 1'b0;
    end else if (conv_done) begin
      conversion_ready_n <= 1'b1;
      fall_pend_reg <= 1'b1;
    end else if (fall_pend_reg) begin
      conversion_ready_n <= 1'b0;
      fall_pend_reg <= 1'b0;
    end else if (sclk_fall && cs_low) begin
      conversion_ready_n <= 1'b1;
    end
  end
  // Output enable lags the pin by the two synchroniser stages plus this one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= cs_low;
    end
  end

  // ==========================================================
  // Conversion pacing
  logic [15:0] pace_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pace_reg <= 16'h0000;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (pace_reg != 16'h0000) begin
        pace_reg <= pace_reg - 16'h0001;
      end else if (pin_sync_reg[3]) begin
        conv_start <= 1'b1;
        pace_reg <= 16'(SCAN_MIN_CYC - 1);
      end
    end
  end

  // ==========================================================
  // Channel selector
  adc_scan_pkg::scan_state_t state_reg;
  logic [4:0] next_code;
  logic [4:0] target_code;
  logic fixed_ok;
  always_comb begin
    next_code = selector.code;
    for (int k = adc_scan_pkg::NUM_SOURCES; k >= 1; k--) begin
      if (channel_enable[(int'(selector.code) + k) % adc_scan_pkg::NUM_SOURCES]) begin
        next_code = 5'((int'(selector.code) + k) % adc_scan_pkg::NUM_SOURCES);
      end
    end
  end
  assign fixed_ok = fixed_channel_addr <= adc_scan_pkg::LAST_CODE;
  assign target_code = (channel_access_mode_bit == adc_scan_pkg::CHANNEL_MODE_AUTO) ?
                       next_code : fixed_channel_addr;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= adc_scan_pkg::SCAN_HOLD;
      selector <= '{open: 1'b0, code: adc_scan_pkg::CODE_RESET};
    end else begin
      unique case (state_reg)
        adc_scan_pkg::SCAN_HOLD: begin
          if (channel_access_mode_bit == adc_scan_pkg::CHANNEL_MODE_AUTO) begin
            if (conv_done && next_code != selector.code) begin
              state_reg <= adc_scan_pkg::SCAN_BREAK;
            end
          end else if (fixed_ok && fixed_channel_addr != selector.code) begin
            state_reg <= adc_scan_pkg::SCAN_BREAK;
          end
        end
        adc_scan_pkg::SCAN_BREAK: begin
          selector.open <= 1'b1;
          state_reg <= adc_scan_pkg::SCAN_MAKE;
        end
        adc_scan_pkg::SCAN_MAKE: begin
          selector.code <= target_code;
          selector.open <= 1'b0;
          state_reg <= adc_scan_pkg::SCAN_HOLD;
        end
      endcase
    end
  end
  for (genvar i = 0; i < adc_scan_pkg::NUM_SOURCES; i++) begin : g_switch
    assign switch_closed[i] = !selector.open && (selector.code == 5'(i));
  end

  // ==========================================================
  // Clock output, crystal mode only
  logic clk_div_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clk_div_reg <= 1'b0;
      clock_pin_bidir_oe <= 1'b0;
    end else begin
      clk_div_reg <= !clk_div_reg;
      clock_pin_bidir_oe <= !pin_sync_reg[4] && pin_sync_reg[5];
    end
  end
  assign clock_pin_bidir_o = clk_div_reg;

  // ==========================================================
  // Checks
  chk_timeout_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    timeout |=> bit_reg == 3'h0)
    else $error("serial bit count not cleared by timeout");
  chk_release_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(cs_n_pin) ##1 cs_n_pin [*3] |-> !dout_oe)
    else $error("serial output still driven after chip select high");
  chk_ready_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    conv_done ##1 !conv_done |-> conversion_ready_n ##1 !conversion_ready_n)
    else $error("ready high pulse not one clock");
  chk_data_lead: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(conversion_ready_n) |-> $stable(dout_o) && $past(conv_done, 2))
    else $error("data not settled before ready fell");
  chk_break_make: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(selector.code) |-> $past(selector.open))
    else $error("channel changed without break");
  chk_one_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $onehot0(switch_closed))
    else $error("more than one source routed");
  chk_fixed_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    channel_access_mode_bit != adc_scan_pkg::CHANNEL_MODE_AUTO &&
    fixed_channel_addr == selector.code && state_reg == adc_scan_pkg::SCAN_HOLD
    |=> state_reg == adc_scan_pkg::SCAN_HOLD)
    else $error("fixed mode advanced by itself");
  chk_start_pace: assert property (@(posedge ref_clk) disable iff (sys_rst)
    conv_start |=> !conv_start [*8])
    else $error("conversion starts too close");
  chk_rise_sample: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_low && !sclk_rise && !timeout |=> $stable(rx_reg))
    else $error("input sampled off rising edge");
  chk_clock_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pin_sync_reg[4] |=> !clock_pin_bidir_oe)
    else $error("clock driven out in external clock mode");

endmodule
`default_nettype wire

/* File: common/adc_scan_pkg.sv */
package adc_scan_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned REF_CLK_HZ = 125_000_000;
  localparam int unsigned TCLK_NS = 8;
  localparam int unsigned TIMEOUT_LONG_TCLK = 4096;
  localparam int unsigned TIMEOUT_SHORT_TCLK = 256;
  localparam int unsigned TIMEOUT_LONG_CYC = TIMEOUT_LONG_TCLK;
  localparam int unsigned TIMEOUT_SHORT_CYC = TIMEOUT_SHORT_TCLK;
  localparam int unsigned CS_RELEASE_MAX_TCLK = 5;
  localparam int unsigned CS_RELEASE_MAX_CYC = CS_RELEASE_MAX_TCLK;
  localparam int unsigned READY_PULSE_CYC = 1;
  // Half a period rounds up to one whole cycle
  localparam int unsigned DATA_LEAD_CYC = 1;
  localparam int unsigned SCAN_RATE_SPS = 23_700;
  localparam int unsigned SCAN_MIN_CYC = (REF_CLK_HZ + SCAN_RATE_SPS - 1) / SCAN_RATE_SPS;
  localparam int unsigned XTAL_HZ = 32_768;

  // ==========================================================
  // Widths and codes
  localparam int unsigned RESULT_BITS = 16;
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned NUM_SOURCES = 29;
  localparam int unsigned FIRST_DIFF_CODE = 16;
  localparam int unsigned FIRST_MON_CODE = 24;
  localparam logic [4:0] LAST_CODE = 5'h1c;
  localparam logic [4:0] CODE_RESET = 5'h00;
  localparam logic [12:0] IDLE_RESET = 13'h0000;
  localparam logic [2:0] BIT_RESET = 3'h0;
  localparam logic CHANNEL_MODE_AUTO = 1'b1;

  typedef enum logic [2:0] {
    SCAN_HOLD = 3'b001,
    SCAN_BREAK = 3'b010,
    SCAN_MAKE = 3'b100
  } scan_state_t;

  typedef struct packed {
    logic open;
    logic [4:0] code;
  } selector_t;

endpackage

/* File: verif/spi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Host side of the serial link, 125 ns bit period
module spi_host_model (
  // Serial pins
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic din_pin,
  input wire logic dout_o
);
  // Clock stands low outside frames
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    din_pin = 1'b0;
  end

  task automatic select(input logic low);
    cs_n_pin = !low;
  endtask

  // Bits MSB first; data set after a fall, read on the rise
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      din_pin = tx[i];
      #62;
      sclk_pin = 1'b1;
      rx = {rx[14:0], dout_o};
      #63;
      sclk_pin = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int NS = adc_scan_pkg::NUM_SOURCES;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk_pin, cs_n_pin, din_pin, dout_o, dout_oe, conversion_ready_n;
  logic start_pin = 1'b0;
  logic conv_done = 1'b0;
  logic [15:0] conv_result = 16'h0000;
  logic conv_start, cmd_valid;
  logic [7:0] cmd_byte;
  logic channel_access_mode_bit = 1'b0;
  logic [NS-1:0] channel_enable = 29'h0000_0001;
  logic [4:0] fixed_channel_addr = 5'h00;
  logic short_timeout = 1'b0;
  adc_scan_pkg::selector_t selector;
  logic [NS-1:0] switch_closed;
  logic clock_src_ext_pin = 1'b0;
  logic clock_out_enable = 1'b0;
  logic clock_pin_bidir_o, clock_pin_bidir_oe;
  logic [31:0] seed = 32'h8447_16c1;
  logic [5:0] prev_sel = 6'h00;
  int n_fail = 0;
  int tests_run = 0;
  int n_cmd = 0;
  int n_bad = 0;

  // Line load pulls a released output low
  spi_host_model host (.sclk_pin, .cs_n_pin, .din_pin, .dout_o(dout_oe ? dout_o : 1'b0));
  adc_serial_port_and_channel_scan #(.SCAN_MIN_CYC(16)) DUT (
    .ref_clk, .sys_rst, .sclk_pin, .cs_n_pin, .din_pin, .dout_o, .dout_oe,
    .conversion_ready_n, .start_pin, .conv_done, .conv_result, .conv_start,
    .cmd_valid, .cmd_byte, .channel_access_mode_bit, .channel_enable,
    .fixed_channel_addr, .short_timeout, .selector, .switch_closed,
    .clock_src_ext_pin, .clock_out_enable, .clock_pin_bidir_o, .clock_pin_bidir_oe
  );

  initial begin
    forever #4 ref_clk = !ref_clk;
  end

  // ==========================================================
  // Monitors: code may only change from the open state
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (!sys_rst && selector.code !== prev_sel[4:0] && prev_sel[5] !== 1'b1) n_bad++;
    if (!sys_rst && !$onehot0(switch_closed)) n_bad++;
    prev_sel <= selector;
  end

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [4:0] next_en(input logic [4:0] cur, input logic [NS-1:0] m);
    for (int i = 1; i <= NS; i++) begin
      if (m[(int'(cur) + i) % NS]) return 5'((int'(cur) + i) % NS);
    end
    return cur;
  endfunction
  task automatic cs(input logic low);
    cyc(1);
    host.select(low);
    cyc(5);
    check(dout_oe, low);
  endtask
  task automatic pulse(input logic [15:0] v);
    conv_result = v;
    conv_done = 1'b1;
    cyc(1);
    conv_done = 1'b0;
  endtask
  // Partial byte, idle gap, rest of byte: merged unless the gap timed out
  task automatic idle_case(input logic sh, input int gap);
    logic [15:0] b, rx;
    int n0;
    b = 16'(rnd());
    short_timeout = sh;
    n0 = n_cmd;
    host.xfer(3, b >> 5, rx);
    cyc(gap);
    host.xfer(5, b, rx);
    if (gap + 16 > (sh ? 256 : 4096)) begin
      host.xfer(3, b, rx);
      cyc(2);
      check(cmd_byte, {b[4:0], b[2:0]});
    end else begin
      cyc(2);
      check(cmd_byte, b[7:0]);
    end
    check(n_cmd, n0 + 1);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Budget covers the 4200-cycle idle case with wide margin
  initial begin
    #600_000;
    n_fail++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] r, rx;
    logic [4:0] a, e;
    int t, hi;
    logic ck;
    cyc(12);
    check(conversion_ready_n, 1'b1);
    check(selector, 6'h00);
    sys_rst = 1'b0;
    cyc(3);
    cs(1'b1);
    for (int k = 0; k < 2; k++) begin
      r = 16'(rnd());
      pulse(r);
      hi = 0;
      repeat (4) begin
        if (conversion_ready_n === 1'b1) begin
          hi++;
          check(dout_o, r[15]);
        end
        cyc(1);
      end
      check(hi, 1);
      check(conversion_ready_n, 1'b0);
    end
    host.xfer(16, 16'(rnd()), rx);
    check(rx, r);
    cyc(2);
    check(conversion_ready_n, 1'b1);
    host.xfer(3, 16'(rnd()), rx);
    cs(1'b0);
    cs(1'b1);
    r = 16'(rnd());
    host.xfer(8, r, rx);
    cyc(2);
    check(cmd_byte, r[7:0]);
    idle_case(1'b1, 200);
    idle_case(1'b1, 300);
    idle_case(1'b0, 300);
    idle_case(1'b0, 4200);
    repeat (6) begin
      a = 5'(rnd() % NS);
      fixed_channel_addr = a;
      cyc(8);
      check(selector.code, a);
      check(switch_closed, 29'h0000_0001 << a);
      pulse(16'(rnd()));
      cyc(8);
      check(selector.code, a);
    end
    channel_enable = 29'(rnd()) | 29'h0000_0001;
    channel_access_mode_bit = 1'b1;
    cyc(8);
    repeat (6) begin
      e = next_en(selector.code, channel_enable);
      pulse(16'(rnd()));
      cyc(8);
      check(selector.code, e);
    end
    start_pin = 1'b1;
    t = 0;
    while (conv_start !== 1'b1 && t < 64) begin
      cyc(1);
      t++;
    end
    t = 0;
    do begin
      cyc(1);
      t++;
    end while (conv_start !== 1'b1 && t < 64);
    check(t, 16);
    start_pin = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {clock_src_ext_pin, clock_out_enable} = 2'(i);
      cyc(6);
      check(clock_pin_bidir_oe, !clock_src_ext_pin && clock_out_enable);
      ck = clock_pin_bidir_o;
      cyc(1);
      check(clock_pin_bidir_o, !ck);
    end
    check(n_bad, 0);
    final_report();
  end
endmodule
`default_nettype wire
